//--- src/flash_read_pkg.sv
// Shared constants and types for the serial flash read controller
package flash_read_pkg;

    // ------------------------------------------------------------------
    // Opcodes and indicator bytes
    // ------------------------------------------------------------------
    localparam logic [7:0] OPC_QUAD_IO_4B = 8'hec;
    localparam logic [7:0] OPC_BURST = 8'h1b;
    localparam logic [7:0] OPC_BURST_4B = 8'h1c;
    localparam logic [7:0] OPC_DDR_READ = 8'h0d;
    localparam logic [7:0] OPC_EXIT_ENH = 8'hff;
    localparam logic [7:0] OPC_FOUR_WIRE_ENTRY = 8'h38;
    localparam logic [7:0] MODE_KEEP = 8'ha5;
    localparam logic [7:0] MODE_DROP = 8'hff;

    // ------------------------------------------------------------------
    // Phase lengths, in serial clocks or bits, and the reference and serial clock rates
    // ------------------------------------------------------------------
    localparam logic [5:0] ADDR_BITS_3B = 6'h18;
    localparam logic [5:0] ADDR_BITS_4B = 6'h20;
    localparam logic [5:0] OPC_BITS = 6'h08;
    localparam logic [5:0] MODE_BITS = 6'h08;
    localparam logic [5:0] QUAD_DUMMY_CLK = 6'h06;
    localparam logic [5:0] ENH_DUMMY_CLK = 6'h04;
    localparam logic [5:0] BURST_DUMMY_CLK = 6'h08;
    localparam logic [5:0] BURST_FW_DUMMY_CLK = 6'h06;
    localparam logic [5:0] DDR_DUMMY_CLK = 6'h04;
    localparam int REF_CLK_MHZ = 25;
    localparam int QUARTERS_PER_SCK = 4;
    localparam int SCK_KHZ = REF_CLK_MHZ * 1000 / QUARTERS_PER_SCK;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        CMD_QUAD_IO_4B = 6'b000001,
        CMD_BURST = 6'b000010,
        CMD_BURST_4B = 6'b000100,
        CMD_DDR_READ = 6'b001000,
        CMD_EXIT_ENH = 6'b010000,
        CMD_FOUR_WIRE_ENTRY = 6'b100000
    } cmd_type;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_OPC = 7'b0000010,
        ST_ADDR = 7'b0000100,
        ST_MODE = 7'b0001000,
        ST_DUMMY = 7'b0010000,
        ST_DATA = 7'b0100000,
        ST_GAP = 7'b1000000
    } state_type;

    typedef struct packed {
        cmd_type cmd;
        logic [31:0] addr;
        logic [15:0] nbytes;
        logic four_byte;
        logic enhance;
    } read_req_type;

    typedef struct packed {
        logic quad;
        logic ddr;
        logic tx;
        logic [5:0] nev;
    } phase_cfg_type;

endpackage

//--- src/flash_read_host.sv
// Host controller issuing fast, burst and double-rate reads to a serial flash
`timescale 1ns/1ps

// Behaviour
// R01: ECh sends 32-bit quad address, six dummies.
// R02: Address launched for rising edge, data four lanes.
// R03: Device increments byte address, wraps at top.
// R04: After ECh opcode, later phases use four lanes.
// R05: Abort raises select during data output.
// R06: Enhance: indicator, four dummies, next frame skips opcode.
// R07: Toggling indicator nibbles keep enhance mode.
// R08: Non-toggling indicator clears enhance mode.
// R09: Lone FFh frame leaves enhance mode.
// R10: Device ignores ECh during internal write cycle.
// R11: Four-wire mode entry 38h, opcode on four lanes.
// R12: 1Bh: opcode, 3/4 address bytes, 8 or 6 dummies.
// R13: Burst data streams until select rises.
// R14: Burst address wraps inside aligned window.
// R15: Window 8, 16, 32 or 64 bytes aligned.
// R16: 1Ch is burst read with four address bytes.
// R17: 0Dh opcode single rate, address and data both edges.
// R18: 0Dh one dummy byte after address.
// R19: Device rejects 0Dh during internal write cycle.
// R20: Device keeps burst window, 8 bytes after reset.
module flash_read_host
    import flash_read_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire read_req_type req_i,
    input wire logic abort_i,
    input wire logic [3:0] io_lane_in_i,
    output logic [3:0] io_lane_out_o,
    output logic [3:0] io_lane_oe_o,
    output logic sck_o,
    output logic cs_n_o,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    output logic done_o,
    output logic refused_o,
    output logic busy_o,
    output logic enhance_active_o,
    output logic four_wire_command_mode_o
);

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        state_type st;
        read_req_type req;
        logic mode_on;
        logic [1:0] q;
        logic sck;
        logic cs_n;
        logic [3:0] lane_out;
        logic [3:0] lane_oe;
        logic [47:0] sh;
        logic [5:0] beats;
        logic [7:0] rx;
        logic [2:0] bitc;
        logic [15:0] bytes;
        logic [7:0] rd_data;
        logic rd_valid;
        logic done;
        logic refused;
        logic busy;
        logic skip;
        logic four_wire_command_mode;
    } ctl_type;

    ctl_type ctl_ff;
    ctl_type nxt_ctl;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Lane shape and beat count of each phase for the active command
    function automatic phase_cfg_type phase_cfg(input state_type st, input read_req_type r,
                                                input logic four_wire_command_mode, input logic mode_on);
        phase_cfg_type c;
        logic [5:0] abits;
        c = '0;
        abits = (r.cmd != CMD_BURST && r.cmd != CMD_DDR_READ) || r.four_byte ? ADDR_BITS_4B : ADDR_BITS_3B;
        c.quad = four_wire_command_mode || r.cmd == CMD_QUAD_IO_4B; // [R04] [R11]
        c.ddr = r.cmd == CMD_DDR_READ && st != ST_OPC; // [R17]
        case (st)
            ST_OPC: begin
                c.quad = four_wire_command_mode; // [R11]
                c.ddr = 1'b0;
                c.tx = 1'b1;
                c.nev = four_wire_command_mode ? OPC_BITS >> 2 : OPC_BITS;
            end
            ST_ADDR: begin
                c.tx = 1'b1;
                c.nev = c.quad ? abits >> 2 : abits; // [R01] [R12] [R16]
            end
            ST_MODE: begin
                c.tx = 1'b1;
                c.nev = MODE_BITS >> 2; // [R06]
            end
            ST_DUMMY: begin
                if (r.cmd == CMD_QUAD_IO_4B) begin
                    c.nev = mode_on ? ENH_DUMMY_CLK : QUAD_DUMMY_CLK; // [R01] [R06]
                end else if (r.cmd == CMD_DDR_READ) begin
                    c.nev = DDR_DUMMY_CLK << 1; // [R18]
                end else begin
                    c.nev = four_wire_command_mode ? BURST_FW_DUMMY_CLK : BURST_DUMMY_CLK; // [R12]
                end
            end
            default: begin
                c.nev = 6'h01;
            end
        endcase
        return c;
    endfunction

    // Phase that follows the given one
    function automatic state_type next_phase(input state_type st, input read_req_type r, input logic mode_on);
        state_type n;
        case (st)
            ST_OPC: n = (r.cmd == CMD_EXIT_ENH || r.cmd == CMD_FOUR_WIRE_ENTRY) ? ST_GAP : ST_ADDR; // [R09]
            ST_ADDR: n = mode_on ? ST_MODE : ST_DUMMY;
            ST_MODE: n = ST_DUMMY;
            ST_DUMMY: n = ST_DATA;
            default: n = ST_GAP;
        endcase
        return n;
    endfunction

    function automatic logic [7:0] opcode_of(input cmd_type cmd);
        logic [7:0] o;
        case (cmd)
            CMD_QUAD_IO_4B: o = OPC_QUAD_IO_4B;
            CMD_BURST: o = OPC_BURST;
            CMD_BURST_4B: o = OPC_BURST_4B;
            CMD_DDR_READ: o = OPC_DDR_READ;
            CMD_EXIT_ENH: o = OPC_EXIT_ENH;
            default: o = OPC_FOUR_WIRE_ENTRY;
        endcase
        return o;
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // One serial clock spans four reference cycles: q0 launch, q1 rise, q2 DDR launch, q3 fall
    always_comb begin
        phase_cfg_type cur;
        phase_cfg_type nc;
        logic [7:0] rx_nxt;
        logic [7:0] mode_byte;
        logic is_4b;
        cur = phase_cfg(ctl_ff.st, ctl_ff.req, ctl_ff.four_wire_command_mode, ctl_ff.mode_on);
        nc = cur;
        rx_nxt = ctl_ff.rx;
        mode_byte = req_i.enhance ? MODE_KEEP : MODE_DROP;
        is_4b = req_i.cmd != CMD_BURST && req_i.cmd != CMD_DDR_READ || req_i.four_byte;
        nxt_ctl = ctl_ff;
        nxt_ctl.rd_valid = 1'b0;
        nxt_ctl.done = 1'b0;
        nxt_ctl.refused = 1'b0;
        case (ctl_ff.st)
            ST_IDLE: begin
                nxt_ctl.sck = 1'b0;
                nxt_ctl.cs_n = 1'b1;
                nxt_ctl.lane_oe = 4'h0;
                if (start_i) begin
                    // Only the quad read or the exit frame may follow an enhanced frame
                    if (ctl_ff.skip && req_i.cmd != CMD_QUAD_IO_4B && req_i.cmd != CMD_EXIT_ENH) begin
                        nxt_ctl.refused = 1'b1;
                    end else begin
                        nxt_ctl.req = req_i;
                        nxt_ctl.mode_on = req_i.cmd == CMD_QUAD_IO_4B && (req_i.enhance || ctl_ff.skip); // [R06]
                        nxt_ctl.cs_n = 1'b0;
                        nxt_ctl.busy = 1'b1;
                        nxt_ctl.q = 2'd0;
                        nxt_ctl.bitc = 3'd0;
                        nxt_ctl.bytes = req_i.nbytes == 16'h0000 ? 16'h0001 : req_i.nbytes;
                        if (ctl_ff.skip && req_i.cmd == CMD_QUAD_IO_4B) begin
                            nxt_ctl.st = ST_ADDR; // [R06]
                            nxt_ctl.sh = {req_i.addr, mode_byte, 8'h00};
                        end else begin
                            nxt_ctl.st = ST_OPC;
                            nxt_ctl.sh = is_4b ? {opcode_of(req_i.cmd), req_i.addr, mode_byte}
                                               : {opcode_of(req_i.cmd), req_i.addr[23:0], mode_byte, 8'h00};
                        end
                        nc = phase_cfg(nxt_ctl.st, nxt_ctl.req, ctl_ff.four_wire_command_mode, nxt_ctl.mode_on);
                        nxt_ctl.beats = nc.nev;
                        nxt_ctl.lane_out = nc.quad ? nxt_ctl.sh[47:44] : {3'b000, nxt_ctl.sh[47]};
                        nxt_ctl.lane_oe = nc.quad ? 4'hf : 4'h1;
                    end
                end
            end
            ST_GAP: begin
                // Select high ends the frame; the modes it armed take effect now
                nxt_ctl.st = ST_IDLE;
                nxt_ctl.cs_n = 1'b1;
                nxt_ctl.sck = 1'b0;
                nxt_ctl.lane_oe = 4'h0;
                nxt_ctl.busy = 1'b0;
                nxt_ctl.done = 1'b1;
                if (ctl_ff.req.cmd == CMD_QUAD_IO_4B) begin
                    nxt_ctl.skip = ctl_ff.req.enhance; // [R06]
                end else if (ctl_ff.req.cmd == CMD_EXIT_ENH) begin
                    nxt_ctl.skip = 1'b0; // [R09]
                end else if (ctl_ff.req.cmd == CMD_FOUR_WIRE_ENTRY) begin
                    nxt_ctl.four_wire_command_mode = 1'b1; // [R11]
                end
            end
            default: begin
                nxt_ctl.q = ctl_ff.q + 2'd1;
                nxt_ctl.sck = nxt_ctl.q == 2'd1 || nxt_ctl.q == 2'd2;
                // Capture read data two quarters after each device launch
                if (ctl_ff.st == ST_DATA && (nxt_ctl.q == 2'd1 || (cur.ddr && nxt_ctl.q == 2'd3))) begin // [R02] [R17]
                    rx_nxt = cur.quad ? {ctl_ff.rx[3:0], io_lane_in_i} : {ctl_ff.rx[6:0], io_lane_in_i[1]};
                    nxt_ctl.rx = rx_nxt;
                    nxt_ctl.bitc = ctl_ff.bitc + (cur.quad ? 3'd4 : 3'd1);
                    if (nxt_ctl.bitc == 3'd0) begin
                        nxt_ctl.rd_data = rx_nxt;
                        nxt_ctl.rd_valid = 1'b1;
                        nxt_ctl.bytes = ctl_ff.bytes - 16'h0001;
                        if (ctl_ff.bytes == 16'h0001) begin
                            nxt_ctl.st = ST_GAP; // [R13]
                        end
                    end
                end
                if (ctl_ff.st == ST_DATA && abort_i) begin
                    nxt_ctl.st = ST_GAP; // [R05]
                end
                // Beat boundary: shift the sent bits away and move on when the phase is used up
                if (ctl_ff.st != ST_DATA && (nxt_ctl.q == 2'd0 || (cur.ddr && nxt_ctl.q == 2'd2))) begin
                    if (cur.tx) begin
                        nxt_ctl.sh = cur.quad ? ctl_ff.sh << 4 : ctl_ff.sh << 1; // [R02]
                    end
                    if (ctl_ff.beats == 6'h01) begin
                        nxt_ctl.st = next_phase(ctl_ff.st, ctl_ff.req, ctl_ff.mode_on);
                        nc = phase_cfg(nxt_ctl.st, ctl_ff.req, ctl_ff.four_wire_command_mode, ctl_ff.mode_on);
                        nxt_ctl.beats = nc.nev;
                    end else begin
                        nxt_ctl.beats = ctl_ff.beats - 6'h01;
                    end
                    // Lanes are released from the dummy phase on so the device can turn them
                    nxt_ctl.lane_out = nc.quad ? nxt_ctl.sh[47:44] : {3'b000, nxt_ctl.sh[47]};
                    nxt_ctl.lane_oe = !nc.tx ? 4'h0 : (nc.quad ? 4'hf : 4'h1);
                end
                if (nxt_ctl.st == ST_GAP) begin
                    nxt_ctl.lane_oe = 4'h0;
                    // No fresh rise once the frame ends, so the device never sees a runt clock pulse
                    nxt_ctl.sck = nxt_ctl.sck && ctl_ff.sck; // [R05]
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ctl_ff <= '0;
            ctl_ff.st <= ST_IDLE;
            ctl_ff.req.cmd <= CMD_QUAD_IO_4B;
            ctl_ff.cs_n <= 1'b1;
        end else begin
            ctl_ff <= nxt_ctl;
        end
    end

    // Every output is a field of the registered state
    assign io_lane_out_o = ctl_ff.lane_out;
    assign io_lane_oe_o = ctl_ff.lane_oe;
    assign sck_o = ctl_ff.sck;
    assign cs_n_o = ctl_ff.cs_n;
    assign rd_data_o = ctl_ff.rd_data;
    assign rd_valid_o = ctl_ff.rd_valid;
    assign done_o = ctl_ff.done;
    assign refused_o = ctl_ff.refused;
    assign busy_o = ctl_ff.busy;
    assign enhance_active_o = ctl_ff.skip;
    assign four_wire_command_mode_o = ctl_ff.four_wire_command_mode;

endmodule

//--- verif/flash_read_host_sva.sv
// Property checker for the serial flash read host
`timescale 1ns/1ps
module flash_read_host_sva
    import flash_read_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire read_req_type req_i,
    input wire logic abort_i,
    input wire logic [3:0] io_lane_oe_o,
    input wire logic sck_o,
    input wire logic cs_n_o,
    input wire logic rd_valid_o,
    input wire logic done_o,
    input wire logic refused_o,
    input wire logic busy_o,
    input wire logic enhance_active_o,
    input wire logic four_wire_command_mode_o
);
    // ------------------------------------------------------------
    // Frame and pin properties
    // ------------------------------------------------------------
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    // Pins rest whenever no frame runs
    idle_pins_a: assert property (!busy_o |-> cs_n_o && !sck_o && io_lane_oe_o == 4'h0)
        else $error("pins active while idle");
    launch_frame_a: assert property (start_i && !busy_o && !enhance_active_o |=> !cs_n_o && busy_o)
        else $error("frame not launched");
    // Only the fast quad read or the exit byte may follow an armed skip mode
    refuse_cmd_a: assert property (start_i && !busy_o && enhance_active_o
        && !(req_i.cmd inside {CMD_QUAD_IO_4B, CMD_EXIT_ENH}) |=> refused_o && cs_n_o)
        else $error("request not refused");
    sck_shape_a: assert property ($rose(sck_o) |-> sck_o ##1 sck_o ##1 !sck_o)
        else $error("serial clock high phase wrong");
    sck_framed_a: assert property (sck_o |-> !cs_n_o)
        else $error("clock outside frame");
    done_follow_a: assert property ($rose(cs_n_o) |-> done_o && !busy_o)
        else $error("done missing after select rise");
    abort_stop_a: assert property (abort_i && $past(rd_valid_o) && !cs_n_o |-> ##[1:2] cs_n_o)
        else $error("abort did not end frame");
    four_lane_a: assert property (four_wire_command_mode_o && !cs_n_o |-> io_lane_oe_o inside {4'h0, 4'hf})
        else $error("partial lane drive in four-wire mode");
    four_sticky_a: assert property (four_wire_command_mode_o |=> four_wire_command_mode_o)
        else $error("four-wire mode dropped");
    done_pulse_a: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
endmodule

bind flash_read_host flash_read_host_sva chk_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .start_i(start_i),
    .req_i(req_i), .abort_i(abort_i), .io_lane_oe_o(io_lane_oe_o), .sck_o(sck_o), .cs_n_o(cs_n_o),
    .rd_valid_o(rd_valid_o), .done_o(done_o), .refused_o(refused_o), .busy_o(busy_o),
    .enhance_active_o(enhance_active_o), .four_wire_command_mode_o(four_wire_command_mode_o));

//--- verif/flash_dev_model.sv
// Behavioural serial flash answering the host's read frames
`timescale 1ns/1ps
module flash_dev_model
    import flash_read_pkg::*;
#(
    parameter int BURST_LEN = 8,
    parameter logic [31:0] ARRAY_MASK = 32'h03ff_ffff
)
(
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic [3:0] lane_i,
    input wire logic [3:0] oe_i,
    input wire logic wip_i,
    output logic [3:0] lane_o
);
    // ------------------------------------------------------------
    // Frame decoding
    // ------------------------------------------------------------
    logic [63:0] sr;
    logic [31:0] base;
    logic [7:0] opc, b;
    logic enh, four_wire_command_mode, burst, wide, ind, rej;
    int nb, e, t, k, d, o;

    // Contents are a fixed function of the address so any byte can be predicted
    function automatic logic [7:0] mem(int i);
        logic [31:0] x;
        x = burst ? ((base & ~(BURST_LEN - 1)) | ((base + i) & (BURST_LEN - 1))) : base + i;
        x = x & ARRAY_MASK;
        return x[7:0] ^ x[15:8];
    endfunction

    initial begin
        enh = 1'b0;
        four_wire_command_mode = 1'b0;
        rej = 1'b0;
        lane_o = 4'h0;
    end

    // Skip mode means the frame opens with the address
    always @(negedge cs_n_i) begin
        nb = 0;
        e = 0;
        t = 0;
        sr = '0;
        opc = enh ? OPC_QUAD_IO_4B : 8'h00;
        rej = 1'b0;
    end

    // Lone command frames act on select rise; data drive stops at once
    always @(posedge cs_n_i) begin
        if (nb == 8 && sr[7:0] == OPC_EXIT_ENH) enh = 1'b0;
        if (nb == 8 && sr[7:0] == OPC_FOUR_WIRE_ENTRY) four_wire_command_mode = 1'b1;
        t = 0;
        lane_o = ~lane_o;
    end

    // Inputs taken on rises (both edges for the double-rate address), data launched after dummies
    always @(posedge sck_i or negedge sck_i) begin
        if (!cs_n_i) begin
            e = e + 1;
            // The fall after the last opcode rise still shows the opcode, so it is not an address bit
            if (oe_i != 4'h0 && (sck_i || (opc == OPC_DDR_READ && nb > 8))) begin
                sr = (oe_i == 4'hf) ? {sr[59:0], lane_i} : {sr[62:0], lane_i[0]};
                nb = nb + ((oe_i == 4'hf) ? 4 : 1);
                if (nb == 8 && !enh) opc = sr[7:0];
            end else if (sck_i && t == 0 && !rej && nb >= 24) begin
                // A busy write cycle makes the array ignore these reads; lanes then float to their pull-ups
                rej = wip_i && opc inside {OPC_QUAD_IO_4B, OPC_DDR_READ};
                o = enh ? 0 : 8;
                ind = opc == OPC_QUAD_IO_4B && nb - o == 40;
                base = ind ? sr[39:8] : sr[31:0];
                if (nb - o == 24) base[31:24] = 8'h00;
                burst = opc inside {OPC_BURST, OPC_BURST_4B};
                wide = opc == OPC_QUAD_IO_4B || four_wire_command_mode;
                d = (opc == OPC_QUAD_IO_4B) ? (ind ? 4 : 6) : burst ? (four_wire_command_mode ? 6 : 8) : 4;
                if (opc == OPC_QUAD_IO_4B && !rej) enh = ind && (&(sr[7:4] ^ sr[3:0]));
                t = rej ? 0 : e + 2 * d - 1;
            end
            if (t != 0 && e >= t && (opc == OPC_DDR_READ || !sck_i)) begin
                k = (opc == OPC_DDR_READ) ? e - t : (e - t) / 2;
                b = mem(wide ? k / 2 : k / 8);
                if (wide) lane_o = k[0] ? b[3:0] : b[7:4];
                else lane_o = {~lane_o[3:2], b[7 - k % 8], ~lane_o[0]};
            end else begin
                lane_o = rej ? 4'hf : ~lane_o;
            end
        end
    end
endmodule

//--- verif/tb.sv
// Self-checking bench for the serial flash read host
`timescale 1ns/1ps
module tb
    import flash_read_pkg::*;
;
    // ------------------------------------------------------------
    // Bench
    // ------------------------------------------------------------
    localparam logic [31:0] AMASK = 32'h03ff_ffff;
    logic ref_clk_i, rst_n_i, start_i, abort_i, sck_o, cs_n_o, rd_valid_o, done_o, refused_o, busy_o;
    logic enhance_active_o, four_wire_command_mode_o;
    read_req_type req_i;
    logic [3:0] io_lane_in_i, io_lane_out_o, io_lane_oe_o, dev_lane;
    logic [7:0] rd_data_o;
    logic dev_wip;
    int failures, tests_run, cyc;
    cmd_type cl[4] = '{CMD_QUAD_IO_4B, CMD_BURST, CMD_BURST_4B, CMD_DDR_READ};

    // The host wins on lanes it enables, the flash elsewhere
    assign io_lane_in_i = (io_lane_out_o & io_lane_oe_o) | (dev_lane & ~io_lane_oe_o);

    flash_read_host dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .start_i(start_i), .req_i(req_i),
        .abort_i(abort_i), .io_lane_in_i(io_lane_in_i), .io_lane_out_o(io_lane_out_o), .io_lane_oe_o(io_lane_oe_o),
        .sck_o(sck_o), .cs_n_o(cs_n_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .done_o(done_o),
        .refused_o(refused_o), .busy_o(busy_o), .enhance_active_o(enhance_active_o),
        .four_wire_command_mode_o(four_wire_command_mode_o));
    flash_dev_model dev_u (.sck_i(sck_o), .cs_n_i(cs_n_o), .lane_i(io_lane_out_o), .oe_i(io_lane_oe_o),
        .wip_i(dev_wip), .lane_o(dev_lane));

    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    // Generous ceiling: the longest frame is some 500 cycles
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            failures++;
            report_and_stop();
        end
    end

    function automatic logic [7:0] exp_b(logic w, logic [31:0] a, int i);
        logic [31:0] x;
        x = w ? {a[31:3], 3'(a[2:0] + i)} : a + i;
        x = x & AMASK;
        return x[7:0] ^ x[15:8];
    endfunction

    task automatic chk(logic [31:0] got, logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One frame: collect every byte, abort after ab bytes when ab is nonzero
    task automatic rd(cmd_type c, logic [31:0] a, int n, logic fb, logic en, int ab);
        int k;
        int t;
        k = 0;
        req_i <= '{c, a, n[15:0], fb, en};
        start_i <= 1'b1;
        @(posedge ref_clk_i);
        start_i <= 1'b0;
        if (!fb && c inside {CMD_BURST, CMD_DDR_READ}) a[31:24] = 8'h00;
        for (t = 0; t < 5000 && done_o !== 1'b1; t++) begin
            @(posedge ref_clk_i);
            if (rd_valid_o === 1'b1) begin
                chk(rd_data_o, dev_wip ? 8'hff : exp_b(c inside {CMD_BURST, CMD_BURST_4B}, a, k));
                k++;
                if (k == ab) abort_i <= 1'b1;
            end
        end
        abort_i <= 1'b0;
        chk(t < 5000, 1'b1);
        chk(k, (ab != 0) ? ab : n);
    endtask

    task automatic report_and_stop();
        $display("comparisons=%0d mismatches=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        rst_n_i = 1'b0;
        start_i = 1'b0;
        abort_i = 1'b0;
        dev_wip = 1'b0;
        req_i = '0;
        void'($urandom(9232));
        repeat (3) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        rd(CMD_BURST, 32'h0000_1206, 10, 1'b0, 1'b0, 0);
        rd(CMD_BURST_4B, 32'h1234_567d, 9, 1'b1, 1'b0, 0);
        rd(CMD_DDR_READ, 32'h00ab_cdef, 3, 1'b0, 1'b0, 0);
        rd(CMD_DDR_READ, 32'h0123_4567, 2, 1'b1, 1'b0, 0);
        rd(CMD_QUAD_IO_4B, 32'h03ff_fffe, 4, 1'b1, 1'b0, 0);
        rd(CMD_QUAD_IO_4B, 32'h0000_0040, 2, 1'b1, 1'b1, 0);
        chk({enhance_active_o, dev_u.enh}, 2'b11);
        rd(CMD_QUAD_IO_4B, 32'h0010_0081, 3, 1'b1, 1'b1, 0);
        req_i <= '{CMD_BURST, 32'h0, 16'h1, 1'b0, 1'b0};
        start_i <= 1'b1;
        @(posedge ref_clk_i);
        start_i <= 1'b0;
        @(posedge ref_clk_i);
        chk(refused_o, 1'b1);
        rd(CMD_QUAD_IO_4B, 32'h0020_0000, 2, 1'b1, 1'b0, 0);
        chk({enhance_active_o, dev_u.enh}, 2'b00);
        rd(CMD_QUAD_IO_4B, 32'h0000_0005, 1, 1'b1, 1'b1, 0);
        rd(CMD_EXIT_ENH, 32'h0, 0, 1'b0, 1'b0, 0);
        chk({enhance_active_o, dev_u.enh}, 2'b00);
        rd(CMD_BURST, 32'h0000_0077, 20, 1'b0, 1'b0, 3);
        for (int i = 0; i < 6; i++) begin
            rd(cl[$urandom % 4], $urandom, 1 + $urandom % 4, 1'($urandom), 1'b0, 0);
        end
        // A write cycle in the flash: quad and double-rate reads are ignored, lanes read as all ones
        dev_wip <= 1'b1;
        rd(CMD_QUAD_IO_4B, 32'h0000_0100, 2, 1'b1, 1'b0, 0);
        rd(CMD_DDR_READ, 32'h0000_0200, 2, 1'b0, 1'b0, 0);
        dev_wip <= 1'b0;
        rd(CMD_FOUR_WIRE_ENTRY, 32'h0, 0, 1'b0, 1'b0, 0);
        chk({four_wire_command_mode_o, dev_u.four_wire_command_mode}, 2'b11);
        rd(CMD_QUAD_IO_4B, 32'h0155_aa10, 3, 1'b1, 1'b0, 0);
        rd(CMD_BURST, 32'h0012_343c, 6, 1'b0, 1'b0, 0);
        report_and_stop();
    end
endmodule
